/* hdl/ccg_pkg.sv */
// package: clock gating controller constants, offsets and bus carrier types
`default_nettype none
package ccg_pkg;
	// ==========================================================
	// register addressing
	localparam logic [31:0] CCG_BASE_ADDR = 32'hC8834400;
	localparam logic [7:0] CCG_IDX_MEDIA_LOW = 8'h50;
	localparam logic [7:0] CCG_IDX_MEDIA_HIGH = 8'h51;
	localparam logic [7:0] CCG_IDX_MEDIA_EXTRA = 8'h52;
	localparam logic [7:0] CCG_IDX_OTHER = 8'h54;
	localparam logic [7:0] CCG_IDX_ALWAYS_ON = 8'h55;
	localparam logic [7:0] CCG_IDX_PLL_DIV = 8'h60;
	localparam int CCG_IDX_SHIFT = 2;
	// ==========================================================
	// reset values
	localparam logic [31:0] CCG_RST_MEDIA = 32'h00000000;
	localparam logic [31:0] CCG_RST_OTHER = 32'h00000000;
	localparam logic [7:0] CCG_RST_ALWAYS_ON = 8'hFF;
	localparam logic [3:0] CCG_RST_PLL_DIV = 4'h0;
	// ==========================================================
	// field positions
	localparam int CCG_AO_USED_W = 8;
	localparam int CCG_AO_GATE_W = 5;
	localparam int CCG_AO_SERIAL_BIT = 4;
	localparam int CCG_AO_CPU_BIT = 0;
	localparam int CCG_ML_SPI_BIT = 30;
	localparam int CCG_ML_HUB_BIT = 19;
	localparam int CCG_ML_DDR_BIT = 0;
	localparam int CCG_MH_AUDIO_TOP_BIT = 15;
	localparam int CCG_MH_AUDIO_XFER_BIT = 8;
	localparam int CCG_MX_MAIN_CLK_BIT = 29;
	localparam int CCG_MX_HDMI_IRQ_BIT = 3;
	localparam int CCG_OT_VIDEO_BIT = 31;
	localparam int CCG_OT_LCD_ENC_BIT = 25;
	localparam int CCG_PLL_VID_LSB = 0;
	localparam int CCG_PLL_MEM_LSB = 2;
	// ==========================================================
	// pll output divider codes
	localparam logic [1:0] CCG_OD_DIV1 = 2'h0;
	localparam logic [1:0] CCG_OD_DIV2 = 2'h1;
	localparam logic [1:0] CCG_OD_DIV4 = 2'h2;
	localparam logic [1:0] CCG_OD_DIV8 = 2'h3;
	// ==========================================================
	// carrier types
	typedef struct packed {
		logic sel;
		logic enable;
		logic write;
		logic [31:0] addr;
		logic [31:0] wdata;
	} ccg_apb_req_t;
	typedef struct packed {
		logic [63:0] media;
		logic [31:0] media_extra;
		logic [31:0] other;
		logic [4:0] always_on;
	} ccg_gates_t;
endpackage : ccg_pkg
`default_nettype wire

/* hdl/ccg_clock_gate_ctrl.sv */
// module: apb clock gating register bank driving per-module clock enables
`default_nettype none
module ccg_clock_gate_ctrl
	import ccg_pkg::*;
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [31:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// clock enables
	output ccg_gates_t o_gates,
	// pll output divider selections
	output logic [1:0] o_video_pll_od,
	output logic [1:0] o_memory_pll_od
);
	// ==========================================================
	// address decode
	function automatic logic [31:0] ccg_addr_of(input logic [7:0] idx);
		ccg_addr_of = CCG_BASE_ADDR + {22'h0, idx, 2'h0};
	endfunction : ccg_addr_of

	function automatic logic [1:0] ccg_mem_od_legal(input logic [1:0] code);
		// memory pll has no divide by eight; such a code falls back to four
		ccg_mem_od_legal = (code == CCG_OD_DIV8) ? CCG_OD_DIV4 : code;
	endfunction : ccg_mem_od_legal

	ccg_apb_req_t req;
	logic access;
	logic setup;
	logic hit_ml;
	logic hit_mh;
	logic hit_mx;
	logic hit_ot;
	logic hit_ao;
	logic hit_pll;
	logic mapped;
	logic [63:0] media_reg;
	logic [31:0] media_extra_reg;
	logic [31:0] other_reg;
	logic [7:0] always_on_reg;
	logic [3:0] pll_div_reg;
	logic [31:0] rdata_next;
	logic [31:0] prdata_reg;
	logic mapped_reg;

	// bundle the bus request
	assign req = '{sel: i_psel, enable: i_penable, write: i_pwrite,
		addr: i_paddr, wdata: i_pwdata};
	assign setup = req.sel & ~req.enable;
	assign access = req.sel & req.enable;

	// decode by full byte address of each word
	always_comb begin
		hit_ml = 1'b0;
		hit_mh = 1'b0;
		hit_mx = 1'b0;
		hit_ot = 1'b0;
		hit_ao = 1'b0;
		hit_pll = 1'b0;
		if (req.addr == ccg_addr_of(CCG_IDX_MEDIA_LOW)) begin
			hit_ml = 1'b1;
		end else if (req.addr == ccg_addr_of(CCG_IDX_MEDIA_HIGH)) begin
			hit_mh = 1'b1;
		end else if (req.addr == ccg_addr_of(CCG_IDX_MEDIA_EXTRA)) begin
			hit_mx = 1'b1;
		end else if (req.addr == ccg_addr_of(CCG_IDX_OTHER)) begin
			hit_ot = 1'b1;
		end else if (req.addr == ccg_addr_of(CCG_IDX_ALWAYS_ON)) begin
			hit_ao = 1'b1;
		end else if (req.addr == ccg_addr_of(CCG_IDX_PLL_DIV)) begin
			hit_pll = 1'b1;
		end
	end
	assign mapped = hit_ml | hit_mh | hit_mx | hit_ot | hit_ao | hit_pll;

	// ==========================================================
	// gating registers
	// media composite enable, low word then high word
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			media_reg <= {CCG_RST_MEDIA, CCG_RST_MEDIA};
		end else if (access && req.write && hit_ml) begin
			media_reg[31:0] <= req.wdata;
		end else if (access && req.write && hit_mh) begin
			media_reg[63:32] <= req.wdata;
		end
	end

	// media extra word
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			media_extra_reg <= CCG_RST_MEDIA;
		end else if (access && req.write && hit_mx) begin
			media_extra_reg <= req.wdata;
		end
	end

	// other domain word
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			other_reg <= CCG_RST_OTHER;
		end else if (access && req.write && hit_ot) begin
			other_reg <= req.wdata;
		end
	end

	// always-on word, only the low byte is storage
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			always_on_reg <= CCG_RST_ALWAYS_ON;
		end else if (access && req.write && hit_ao) begin
			always_on_reg <= req.wdata[CCG_AO_USED_W-1:0];
		end
	end

	// pll output divider codes
	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			pll_div_reg <= CCG_RST_PLL_DIV;
		end else if (access && req.write && hit_pll) begin
			pll_div_reg <= {ccg_mem_od_legal(req.wdata[CCG_PLL_MEM_LSB +: 2]),
				req.wdata[CCG_PLL_VID_LSB +: 2]};
		end
	end

	// ==========================================================
	// read path, captured in the setup phase
	always_comb begin
		rdata_next = 32'h00000000;
		if (hit_ml) begin
			rdata_next = media_reg[31:0];
		end else if (hit_mh) begin
			rdata_next = media_reg[63:32];
		end else if (hit_mx) begin
			rdata_next = media_extra_reg;
		end else if (hit_ot) begin
			rdata_next = other_reg;
		end else if (hit_ao) begin
			rdata_next = {24'h000000, always_on_reg};
		end else if (hit_pll) begin
			rdata_next = {28'h0000000, pll_div_reg};
		end
	end

	always_ff @(posedge i_clk_sys) begin
		if (i_sys_rst) begin
			prdata_reg <= 32'h00000000;
			mapped_reg <= 1'b0;
		end else if (setup) begin
			prdata_reg <= rdata_next;
			mapped_reg <= mapped;
		end
	end

	// zero wait state slave; unmapped access answers with an error
	assign o_pready = 1'b1;
	assign o_prdata = prdata_reg;
	assign o_pslverr = access & ~mapped_reg;

	// ==========================================================
	// enable outputs straight from flops so they cannot glitch
	// one assignment drives the whole carrier so it has a single driver
	assign o_gates = '{media: media_reg,
		media_extra: media_extra_reg,
		other: other_reg,
		always_on: always_on_reg[CCG_AO_GATE_W-1:0]};
	assign o_video_pll_od = pll_div_reg[CCG_PLL_VID_LSB +: 2];
	assign o_memory_pll_od = pll_div_reg[CCG_PLL_MEM_LSB +: 2];

	// ==========================================================
	// assertions
	default clocking ccg_cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	property p_media_low_write;
		access && req.write && hit_ml |=> o_gates.media[31:0] == $past(req.wdata);
	endproperty
	a_media_low_write: assert property (p_media_low_write)
		else $error("media low word not written");

	property p_media_high_write;
		access && req.write && hit_mh |=> o_gates.media[63:32] == $past(req.wdata)
			&& $stable(o_gates.media[31:0]);
	endproperty
	a_media_high_write: assert property (p_media_high_write)
		else $error("media high word write wrong");

	property p_extra_write;
		access && req.write && hit_mx ##1 1'b1 |->
			o_gates.media_extra == $past(req.wdata);
	endproperty
	a_extra_write: assert property (p_extra_write)
		else $error("media extra gates not following write");

	property p_other_write;
		access && req.write && hit_ot |=> o_gates.other == $past(req.wdata);
	endproperty
	a_other_write: assert property (p_other_write)
		else $error("other domain gates not following write");

	property p_ao_write;
		access && req.write && hit_ao |=> o_gates.always_on == $past(req.wdata[CCG_AO_GATE_W-1:0]);
	endproperty
	a_ao_write: assert property (p_ao_write)
		else $error("always-on gates not following write");

	property p_other_hold;
		!(access && req.write && hit_ot) |=> $stable(o_gates.other);
	endproperty
	a_other_hold: assert property (p_other_hold)
		else $error("other domain gates changed without write");

	property p_ao_unused_zero;
		setup && hit_ao ##1 access |-> o_prdata[31:CCG_AO_USED_W] == 24'h000000;
	endproperty
	a_ao_unused_zero: assert property (p_ao_unused_zero)
		else $error("always-on unused bits read nonzero");

	property p_readback;
		setup && hit_ot && !i_sys_rst ##1 access |-> o_prdata == o_gates.other;
	endproperty
	a_readback: assert property (p_readback)
		else $error("read data differs from other domain gates");

	property p_mem_od_legal;
		o_memory_pll_od != CCG_OD_DIV8;
	endproperty
	a_mem_od_legal: assert property (p_mem_od_legal)
		else $error("memory pll divide by eight selected");

	property p_video_od_write;
		access && req.write && hit_pll |=>
			o_video_pll_od == $past(req.wdata[CCG_PLL_VID_LSB +: 2]);
	endproperty
	a_video_od_write: assert property (p_video_od_write)
		else $error("video pll divider code not following write");

	property p_prdata_hold;
		!setup |=> $stable(o_prdata);
	endproperty
	a_prdata_hold: assert property (p_prdata_hold)
		else $error("read data moved outside a setup phase");

	property p_err_in_access;
		o_pslverr |-> access && !$past(mapped);
	endproperty
	a_err_in_access: assert property (p_err_in_access)
		else $error("error flagged outside an unmapped access");

	property p_unmapped_err;
		setup && !mapped ##1 access |-> o_pslverr && o_pready;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err)
		else $error("unmapped access not flagged");

	property p_glitch_free;
		$changed(o_gates.media) |->
			$past(access && req.write && (hit_ml || hit_mh)) || $past(i_sys_rst);
	endproperty
	a_glitch_free: assert property (p_glitch_free)
		else $error("media gates moved without a bus write");

	property p_cov_ao_off;
		access && req.write && hit_ao && !req.wdata[CCG_AO_CPU_BIT];
	endproperty
	c_ao_off: cover property (p_cov_ao_off);

	property p_cov_video_div8;
		access && req.write && hit_pll ##1 o_video_pll_od == CCG_OD_DIV8;
	endproperty
	c_video_div8: cover property (p_cov_video_div8);

	property p_cov_bad_addr;
		access && o_pslverr;
	endproperty
	c_bad_addr: cover property (p_cov_bad_addr);

	property p_cov_media_high;
		access && req.write && hit_mh ##1 o_gates.media[63:32] != 32'h00000000;
	endproperty
	c_media_high: cover property (p_cov_media_high);

	property p_cov_readback;
		setup && hit_ot ##1 access && o_prdata != 32'h00000000;
	endproperty
	c_readback: cover property (p_cov_readback);

endmodule : ccg_clock_gate_ctrl
`default_nettype wire

/* tb/ccg_apb_master.sv */
// partner: apb bus master model issuing register accesses
`default_nettype none
module ccg_apb_master
	import ccg_pkg::*;
(
	// clock
	input wire logic i_clk_sys,
	// apb master side
	output ccg_apb_req_t o_req,
	input wire logic [31:0] i_prdata,
	input wire logic i_pready,
	input wire logic i_pslverr
);
	timeunit 1ns;
	timeprecision 1ns;
	initial o_req = '0;
	// ==========================================================
	// one transfer: setup, access, hold until ready is sampled high
	task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		n = 0;
		@(negedge i_clk_sys);
		o_req = '{sel: 1'b1, enable: 1'b0, write: wr, addr: addr, wdata: wd};
		@(negedge i_clk_sys);
		o_req.enable = 1'b1;
		@(posedge i_clk_sys);
		while (i_pready !== 1'b1 && n < 16) begin
			@(posedge i_clk_sys);
			n++;
		end
		rd = i_prdata;
		err = i_pslverr;
		if (i_pready !== 1'b1) begin
			// no ready seen: hand back unknowns so the caller's compare fails
			rd = 32'hXXXXXXXX;
			err = 1'bx;
		end
		// leave the access phase at the next falling edge, address and write data lines showing the inverse
		@(negedge i_clk_sys);
		o_req = '{sel: 1'b0, enable: 1'b0, write: wr, addr: ~addr, wdata: ~wd};
	endtask : xfer
	// release: address and write data lines show the inverse of their last value, write keeps its level
	task automatic idle();
		@(negedge i_clk_sys);
		o_req = '{sel: 1'b0, enable: 1'b0, write: o_req.write, addr: ~o_req.addr,
			wdata: ~o_req.wdata};
	endtask : idle
endmodule : ccg_apb_master
`default_nettype wire

/* tb/clock_gating_controller_test.sv */
// testbench: register accesses and clock enable checks
`default_nettype none
module clock_gating_controller_test
	import ccg_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_sys;
	logic sys_rst;
	ccg_apb_req_t req;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	ccg_gates_t gates;
	logic [1:0] vod;
	logic [1:0] mod;
	logic [31:0] rd;
	logic er;
	logic [31:0] pat [4];
	int bad_count = 0;
	int checks_done = 0;
	ccg_clock_gate_ctrl ccg_clock_gate_ctrl_i (.i_clk_sys(clk_sys), .i_sys_rst(sys_rst),
		.i_psel(req.sel), .i_penable(req.enable), .i_pwrite(req.write), .i_paddr(req.addr),
		.i_pwdata(req.wdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.o_gates(gates), .o_video_pll_od(vod), .o_memory_pll_od(mod));
	ccg_apb_master ccg_apb_master_i (.i_clk_sys(clk_sys), .o_req(req), .i_prdata(prdata),
		.i_pready(pready), .i_pslverr(pslverr));
	// ==========================================================
	// helpers
	function automatic logic [31:0] addr_of(input logic [7:0] idx);
		return 32'hC8834400 + {22'h0, idx, 2'h0};
	endfunction : addr_of
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [7:0] idx, input logic [31:0] d, input logic e);
		ccg_apb_master_i.xfer(1'b1, addr_of(idx), d, rd, er);
		chk("write error", {63'h0, e}, {63'h0, er});
	endtask : wr
	task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input logic e);
		ccg_apb_master_i.xfer(1'b0, addr_of(idx), 32'h0, rd, er);
		chk("read data", {32'h0, exp}, {32'h0, rd});
		chk("read error", {63'h0, e}, {63'h0, er});
		chk("ready", 64'h1, {63'h0, pready});
	endtask : rdc
	task automatic gchk(input logic [63:0] m, input logic [31:0] x, input logic [31:0] o,
		input logic [4:0] a);
		@(negedge clk_sys);
		chk("media gates", m, gates.media);
		chk("extra gates", {32'h0, x}, {32'h0, gates.media_extra});
		chk("other gates", {32'h0, o}, {32'h0, gates.other});
		chk("always on gates", {59'h0, a}, {59'h0, gates.always_on});
	endtask : gchk
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : tally_and_finish
	// ==========================================================
	// clock and watchdog
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	initial begin
		#400000;
		bad_count++;
		tally_and_finish();
	end
	// ==========================================================
	// tests
	initial begin
		sys_rst = 1'b1;
		repeat (3) @(negedge clk_sys);
		sys_rst = 1'b0;
		gchk(64'h0, 32'h0, 32'h0, 5'h1F);
		rdc(8'h50, 32'h0, 1'b0);
		rdc(8'h55, 32'h000000FF, 1'b0);
		rdc(8'h60, 32'h0, 1'b0);
		$display("test reset values done");
		// drive every enable bit of the wide words both high and low across two passes
		pat = '{32'h400B03C1, 32'hC1F0E104, 32'h26000B18, 32'h87000000};
		for (int p = 0; p < 2; p++) begin
			// second pass writes the complement, so the gates end up holding pat
			if (p == 1) begin
				foreach (pat[i]) pat[i] = ~pat[i];
			end
			wr(8'h50, pat[0], 1'b0);
			wr(8'h51, pat[1], 1'b0);
			wr(8'h52, pat[2], 1'b0);
			wr(8'h54, pat[3], 1'b0);
			gchk({pat[1], pat[0]}, pat[2], pat[3], 5'h1F);
			rdc(8'h51, pat[1], 1'b0);
			rdc(8'h54, pat[3], 1'b0);
		end
		$display("test wide words done");
		wr(8'h55, 32'hFFFFFFE0, 1'b0);
		rdc(8'h55, 32'h000000E0, 1'b0);
		gchk({pat[1], pat[0]}, pat[2], pat[3], 5'h00);
		wr(8'h55, 32'h00000015, 1'b0);
		gchk({pat[1], pat[0]}, pat[2], pat[3], 5'h15);
		$display("test always on done");
		wr(8'h53, 32'hFFFFFFFF, 1'b1);
		rdc(8'h56, 32'h0, 1'b1);
		rdc(8'h52, pat[2], 1'b0);
		gchk({pat[1], pat[0]}, pat[2], pat[3], 5'h15);
		$display("test unmapped done");
		for (int c = 0; c < 4; c++) begin
			wr(8'h60, {28'h0, c[1:0], c[1:0]}, 1'b0);
			@(negedge clk_sys);
			chk("video od", {62'h0, c[1:0]}, {62'h0, vod});
			chk("memory od", (c == 3) ? 64'h2 : 64'(c), {62'h0, mod});
			rdc(8'h60, (c == 3) ? 32'hB : {28'h0, c[1:0], c[1:0]}, 1'b0);
		end
		$display("test pll dividers done");
		ccg_apb_master_i.idle();
		sys_rst = 1'b1;
		@(negedge clk_sys);
		sys_rst = 1'b0;
		gchk(64'h0, 32'h0, 32'h0, 5'h1F);
		$display("test second reset done");
		tally_and_finish();
	end
endmodule : clock_gating_controller_test
`default_nettype wire
